// File: rtl/fepc_top.sv
// fepc_top: configuration decode and fine value staging for a fine edge pwm channel
// assumes the coarse time base and micro-edge delay line sit outside, on aclk
//
// Summary of operation
// - auto-scale on multiplies fine value by scale
// - auto-scale off takes value as pre-scaled
// - second output normal or inverted first
// - load select picks zero, period, either
// - zero and period events from counter compare
// - control select picks compare/period or phase
// - edge select zero disables fine placement
// - codes one/two move rising/falling with compare or phase
// - code three moves both edges
`timescale 1ns/1ps
module fepc_top import fepc_pkg::*; #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // coarse time base, same clock
  input wire logic [CNT_W-1:0] time_base_count,
  input wire logic [CNT_W-1:0] period_value,
  // channel signals before output selection
  input wire logic first_channel_signal,
  input wire logic second_channel_signal,
  // channel outputs
  output logic first_channel_output,
  output logic second_channel_output,
  // to the micro-edge positioner
  output logic [15:0] mep_fine_value,
  output logic mep_rise_enable,
  output logic mep_fall_enable,
  output logic mep_phase_mode,
  output logic fine_load_pulse
);
  initial begin
    if (CNT_W < 1 || CNT_W > 16) $error("CNT_W must be 1..16");
  end

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] scale;
    logic [7:0] cmp_shadow;
    logic [7:0] cmp_active;
    logic [7:0] prd;
    logic [7:0] phs;
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] fine;
    logic rise;
    logic fall;
    logic phase;
    logic load;
    logic out_a;
    logic out_b;
  } fepc_state_t;

  fepc_state_t st_q, st_d;

  // state layout notes:
  // cfg holds the six configuration fields in eight bits, bit 7 kept only for software
  // scale is the hardware multiplier used when auto-scale is on
  // cmp_shadow takes bus writes; cmp_active only moves on a load event,
  // so a write in mid-period never disturbs the edge being placed now
  // prd and phs are not shadowed here, they reach the fine value one clock after the write commits
  // aw_got/w_got remember a half-taken write until the other half arrives
  // bvalid/rvalid are the answer flags, each held until its ready
  // fine, rise, fall, phase and load are the registered positioner outputs
  // out_a/out_b are the registered channel outputs

  logic auto_scale_enable;
  logic second_output_select;
  fepc_load_t fine_load_select;
  logic fine_control_select;
  fepc_edge_t edge_select;
  // counter events and the event picked by the load select field
  logic zero_evt;
  logic prd_evt;
  logic load_evt;
  // fine value before and after scaling
  logic [7:0] raw_fine;
  logic [15:0] scaled;

  // field decode of the configuration register
  assign auto_scale_enable = st_q.cfg[FEPC_AUTO_BIT];
  assign second_output_select = st_q.cfg[FEPC_SELB_BIT];
  assign fine_load_select = fepc_load_t'(st_q.cfg[FEPC_LOAD_LSB +: 2]);
  assign fine_control_select = st_q.cfg[FEPC_CTL_BIT];
  assign edge_select = fepc_edge_t'(st_q.cfg[FEPC_EDGE_LSB +: 2]);

  // counter events, compared on the live counter
  assign zero_evt = (time_base_count == FEPC_ZERO_COUNT[CNT_W-1:0]);
  assign prd_evt = (time_base_count == period_value);

  // load event decode; reserved code never loads
  always_comb begin
    case (fine_load_select)
      FEPC_LD_ZERO: load_evt = zero_evt;
      FEPC_LD_PRD: load_evt = prd_evt;
      FEPC_LD_BOTH: load_evt = zero_evt | prd_evt;
      FEPC_LD_RSVD: load_evt = 1'b0;
      default: load_evt = 1'b0;
    endcase
  end

  // edge source pick: both-edge mode uses phase or period, single edge uses phase or compare
  // single-edge modes with control select set still use phase, which keeps
  // phase control usable for either edge alone
  // the active compare, not the shadow, is used so the edge moves only on
  // a load event
  always_comb begin
    if (edge_select == FEPC_EDGE_BOTH) begin
      raw_fine = fine_control_select ? st_q.phs : st_q.prd;
    end else if (fine_control_select) begin
      raw_fine = st_q.phs;
    end else begin
      raw_fine = st_q.cmp_active;
    end
  end

  // hardware scaling costs one 8x8 multiplier; off means value is used as written
  assign scaled = auto_scale_enable ? 16'(raw_fine * st_q.scale) : {raw_fine, 8'h00};

  // all next-state logic
  always_comb begin
    logic [31:0] wd;
    logic wr_ok, rd_ok;
    wd = st_q.w_data;
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    st_d = st_q;
    // accept address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_got = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    // write commit once both halves are held; byte lane 0 carries the cfg and scale fields
    // commit waits one cycle after the second half is taken, which costs a
    // cycle of latency but keeps the address decode off the bus inputs
    // fine registers sit in byte lane 1, matching their upper-byte layout
    // an unmapped address still answers, with an error code and no effect
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      wr_ok = 1'b1;
      case (st_q.aw_addr[11:2])
        FEPC_CFG_ADDR[11:2]: begin
          if (st_q.w_strb[0]) st_d.cfg = wd[7:0] & FEPC_CFG_MASK;
        end
        FEPC_SCALE_ADDR[11:2]: begin
          if (st_q.w_strb[0]) st_d.scale = wd[7:0];
        end
        FEPC_FINE_CMP_ADDR[11:2]: begin
          if (st_q.w_strb[1]) st_d.cmp_shadow = wd[FEPC_FINE_LSB +: 8];
        end
        FEPC_FINE_PRD_ADDR[11:2]: begin
          if (st_q.w_strb[1]) st_d.prd = wd[FEPC_FINE_LSB +: 8];
        end
        FEPC_FINE_PHS_ADDR[11:2]: begin
          if (st_q.w_strb[1]) st_d.phs = wd[FEPC_FINE_LSB +: 8];
        end
        FEPC_STATUS_ADDR[11:2]: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = wr_ok ? FEPC_RESP_OKAY : FEPC_RESP_SLVERR;
    end
    // shadow to active on the selected counter event
    if (load_evt) begin
      st_d.cmp_active = st_q.cmp_shadow;
    end
    // read path
    // read data is registered straight from the address, so rvalid rises
    // right after the address is taken; arready stays low until rdata is
    // taken, so a second read can never overwrite data not yet seen
    // the status word is the only way to see the active compare value
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd_ok = 1'b1;
      st_d.rdata = 32'h0000_0000;
      case (s_axi_araddr[11:2])
        FEPC_CFG_ADDR[11:2]: st_d.rdata[7:0] = st_q.cfg;
        FEPC_SCALE_ADDR[11:2]: st_d.rdata[7:0] = st_q.scale;
        FEPC_FINE_CMP_ADDR[11:2]: st_d.rdata[FEPC_FINE_LSB +: 8] = st_q.cmp_shadow;
        FEPC_FINE_PRD_ADDR[11:2]: st_d.rdata[FEPC_FINE_LSB +: 8] = st_q.prd;
        FEPC_FINE_PHS_ADDR[11:2]: st_d.rdata[FEPC_FINE_LSB +: 8] = st_q.phs;
        FEPC_STATUS_ADDR[11:2]: st_d.rdata[15:0] = {st_q.cmp_active, 5'h00, st_q.phase, st_q.fall, st_q.rise};
        default: rd_ok = 1'b0;
      endcase
      st_d.rvalid = 1'b1;
      st_d.rresp = rd_ok ? FEPC_RESP_OKAY : FEPC_RESP_SLVERR;
    end
    // edge enables to the micro-edge positioner
    case (edge_select)
      FEPC_EDGE_OFF: begin
        st_d.rise = 1'b0;
        st_d.fall = 1'b0;
      end
      FEPC_EDGE_RISE: begin
        st_d.rise = 1'b1;
        st_d.fall = 1'b0;
      end
      FEPC_EDGE_FALL: begin
        st_d.rise = 1'b0;
        st_d.fall = 1'b1;
      end
      FEPC_EDGE_BOTH: begin
        st_d.rise = 1'b1;
        st_d.fall = 1'b1;
      end
      default: begin
        st_d.rise = 1'b0;
        st_d.fall = 1'b0;
      end
    endcase
    // coarse edges only when disabled, so the value is zeroed too
    st_d.fine = (edge_select == FEPC_EDGE_OFF) ? 16'h0000 : scaled;
    st_d.phase = fine_control_select;
    st_d.load = load_evt;
    // output select; the swap bit is stored but steers nothing here
    st_d.out_a = first_channel_signal;
    st_d.out_b = second_output_select ? ~first_channel_signal : second_channel_signal;
  end

  // single state register
  // reset clears every field; the configuration reset value is applied on top
  // so that a non-zero default would need only a package change
  // reset is synchronous, so it must be held over at least one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.cfg <= FEPC_CFG_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // bus handshakes; one write and one read outstanding at most
  // the ready outputs are combinational from state only, never from valid,
  // so no combinational loop can form with a master that waits on ready
  // limitation: no write and read ordering is enforced between channels;
  // a read issued alongside a write may see the old register value
  // write ready signals drop while a response waits, which also blocks
  // a new address from being taken before the old one is answered
  assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  // registered outputs
  // all outputs lag their cause by one cycle; the positioner sees settled
  // values only, at the price of that cycle of delay
  assign first_channel_output = st_q.out_a;
  assign second_channel_output = st_q.out_b;
  assign mep_fine_value = st_q.fine;
  assign mep_rise_enable = st_q.rise;
  assign mep_fall_enable = st_q.fall;
  assign mep_phase_mode = st_q.phase;
  assign fine_load_pulse = st_q.load;
endmodule

// File: include/fepc_pkg.sv
// fepc_pkg: register map, field layout and encodings of the fine edge pwm config block
// assumes a 32-bit axi4-lite slave with one aligned word per register
package fepc_pkg;
  localparam logic [11:0] FEPC_CFG_ADDR = 12'h080;
  localparam logic [11:0] FEPC_SCALE_ADDR = 12'h098;
  localparam logic [11:0] FEPC_FINE_CMP_ADDR = 12'h020;
  localparam logic [11:0] FEPC_FINE_PRD_ADDR = 12'h018;
  localparam logic [11:0] FEPC_FINE_PHS_ADDR = 12'h008;
  localparam logic [11:0] FEPC_STATUS_ADDR = 12'h0c0;
  localparam int FEPC_EDGE_LSB = 0;
  localparam int FEPC_CTL_BIT = 2;
  localparam int FEPC_LOAD_LSB = 3;
  localparam int FEPC_SELB_BIT = 5;
  localparam int FEPC_AUTO_BIT = 6;
  localparam int FEPC_SWAP_BIT = 7;
  localparam int FEPC_FINE_LSB = 8;
  localparam logic [7:0] FEPC_CFG_RST = 8'h00;
  localparam logic [7:0] FEPC_CFG_MASK = 8'hff;
  localparam logic [15:0] FEPC_ZERO_COUNT = 16'h0000;
  localparam logic [1:0] FEPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] FEPC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {FEPC_LD_ZERO, FEPC_LD_PRD, FEPC_LD_BOTH, FEPC_LD_RSVD} fepc_load_t;
  typedef enum logic [1:0] {FEPC_EDGE_OFF, FEPC_EDGE_RISE, FEPC_EDGE_FALL, FEPC_EDGE_BOTH} fepc_edge_t;
endpackage

// File: tb/fepc_props.sv
// fepc_props: port-level checks of the fine edge pwm config block
// assumes one clock aclk and synchronous active-low aresetn
`timescale 1ns/1ps
module fepc_props import fepc_pkg::*; #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic aclk, aresetn,
  // bus handshakes
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // time base and channel
  input wire logic [CNT_W-1:0] time_base_count, period_value,
  input wire logic first_channel_signal, second_channel_signal, first_channel_output, second_channel_output,
  // positioner side
  input wire logic [15:0] mep_fine_value,
  input wire logic mep_rise_enable, mep_fall_enable, fine_load_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // $past guard keeps the first edge after reset quiet
  chk_first_delay: assert property ($past(aresetn) |-> first_channel_output == $past(first_channel_signal))
    else $error("first output is not the delayed input");
  chk_second_sel: assert property ($past(aresetn) |->
    second_channel_output == ~$past(first_channel_signal) || second_channel_output == $past(second_channel_signal))
    else $error("second output is neither source");
  chk_load_event: assert property (fine_load_pulse |->
    $past(time_base_count) == '0 || $past(time_base_count) == $past(period_value))
    else $error("load pulse without a counter event");
  chk_off_value: assert property (!(mep_rise_enable || mep_fall_enable) |-> mep_fine_value == 16'h0000)
    else $error("fine value while placement is off");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  chk_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
endmodule
bind fepc_top fepc_props #(.CNT_W(CNT_W)) u_fepc_props (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .time_base_count, .period_value, .first_channel_signal, .second_channel_signal, .first_channel_output,
  .second_channel_output, .mep_fine_value, .mep_rise_enable, .mep_fall_enable, .fine_load_pulse);

// File: tb/tb_fepc_top.sv
// tb_fepc_top: self-checking bench for fepc_top
// assumes the bench alone drives the bus, time base and channel inputs
`timescale 1ns/1ps
module tb_fepc_top import fepc_pkg::*; ;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] time_base_count = 16'h0005, period_value = 16'h0009, mep_fine_value;
  logic first_channel_signal = 0, second_channel_signal = 0, first_channel_output, second_channel_output;
  logic mep_rise_enable, mep_fall_enable, mep_phase_mode, fine_load_pulse;
  logic [7:0] act;
  int fail_count = 0, n_tests = 0, cyc = 0;
  fepc_top u_fepc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .time_base_count, .period_value, .first_channel_signal, .second_channel_signal, .first_channel_output,
    .second_channel_output, .mep_fine_value, .mep_rise_enable, .mep_fall_enable, .mep_phase_mode,
    .fine_load_pulse);
  always #2 aclk = ~aclk;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // lone write: both halves offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
      if (!dd && s_axi_wready) begin dd = 1; s_axi_wvalid <= 0; end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1; // late ready exercises response hold
    @(posedge aclk);
    s_axi_bready <= 0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1;
    @(posedge aclk);
    s_axi_rready <= 0; rv = s_axi_rdata; rr = s_axi_rresp;
  endtask
  task automatic t_reset;
    aresetn <= 0; repeat (2) @(posedge aclk); aresetn <= 1; act = 8'h00;
    rd(FEPC_CFG_ADDR); chk(rv, 32'h0);
    chk({mep_rise_enable, mep_fall_enable, mep_fine_value, fine_load_pulse}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_regs;
    wr(FEPC_CFG_ADDR, 32'hff, FEPC_RESP_OKAY); rd(FEPC_CFG_ADDR); chk(rv, 32'hff);
    wr(12'h004, 32'h1, FEPC_RESP_SLVERR); rd(12'h004); chk(rr, FEPC_RESP_SLVERR);
    wr(FEPC_STATUS_ADDR, 32'h1, FEPC_RESP_OKAY);
    $display("test regs done");
  endtask
  // one counter cycle at v, then pulse and active compare judged
  task automatic ev(input logic [15:0] v, input logic hit, input logic [7:0] nv);
    @(posedge aclk) time_base_count <= v;
    @(posedge aclk) time_base_count <= 16'h0005;
    @(posedge aclk) chk(fine_load_pulse, hit);
    if (hit) act = nv;
    rd(FEPC_STATUS_ADDR); chk(rv[15:8], act);
  endtask
  task automatic t_load;
    for (int ld = 0; ld < 4; ld++) begin
      wr(FEPC_CFG_ADDR, 32'(ld << FEPC_LOAD_LSB) | 32'h1, FEPC_RESP_OKAY);
      wr(FEPC_FINE_CMP_ADDR, 32'(ld + 16) << 8, FEPC_RESP_OKAY);
      ev(16'h0000, ld == 0 || ld == 2, 8'(ld + 16));
      wr(FEPC_FINE_CMP_ADDR, 32'(ld + 32) << 8, FEPC_RESP_OKAY);
      ev(period_value, ld == 1 || ld == 2, 8'(ld + 32));
    end
    $display("test load done");
  endtask
  task automatic t_edges;
    logic [15:0] ex;
    wr(FEPC_FINE_PHS_ADDR, 32'h0500, FEPC_RESP_OKAY);
    wr(FEPC_FINE_PRD_ADDR, 32'h0700, FEPC_RESP_OKAY);
    for (int c = 0; c < 2; c++) begin
      for (int e = 0; e < 4; e++) begin
        wr(FEPC_CFG_ADDR, 32'(c * 4 + e), FEPC_RESP_OKAY);
        ex = (e == 0) ? 16'h0000 : {(c == 1) ? 8'h05 : (e == 3) ? 8'h07 : act, 8'h00};
        chk({mep_rise_enable, mep_fall_enable}, {e[0], e[1]});
        chk(mep_fine_value, ex);
        chk(mep_phase_mode, c[0]);
      end
    end
    wr(FEPC_SCALE_ADDR, 32'h3, FEPC_RESP_OKAY);
    wr(FEPC_CFG_ADDR, 32'h41, FEPC_RESP_OKAY);
    chk(mep_fine_value, {8'h00, act} * 16'd3);
    $display("test edges done");
  endtask
  task automatic t_selb;
    for (int s = 0; s < 2; s++) begin
      wr(FEPC_CFG_ADDR, 32'(s << FEPC_SELB_BIT), FEPC_RESP_OKAY);
      for (int v = 0; v < 4; v++) begin
        first_channel_signal <= v[0]; second_channel_signal <= v[1];
        repeat (2) @(posedge aclk);
        chk(first_channel_output, v[0]);
        chk(second_channel_output, s ? !v[0] : v[1]);
      end
    end
    $display("test selb done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence, second reset at the end of the run
  initial begin
    t_reset(); t_regs(); t_load(); t_edges(); t_selb(); t_reset();
    final_report();
  end
endmodule
